// *** rtl/irq_ctrl_pkg.sv ***
package irq_ctrl_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [3:0] reg_addr_t;
  typedef logic [3:0] src_idx_t;

  // Register indices in data memory
  localparam reg_addr_t ADDR_EDGE = 4'h0;
  localparam reg_addr_t ADDR_PRI0 = 4'h1;
  localparam reg_addr_t ADDR_PRI1 = 4'h2;
  localparam reg_addr_t ADDR_PRI2 = 4'h3;
  localparam reg_addr_t ADDR_PRI3 = 4'h4;
  localparam reg_addr_t ADDR_GRP0 = 4'h5;
  localparam reg_addr_t ADDR_GRP1 = 4'h6;
  localparam reg_addr_t ADDR_GRP2 = 4'h7;
  localparam reg_addr_t ADDR_GRP3 = 4'h8;
  localparam int NUM_REGS = 9;

  // Implemented bits of each register
  localparam byte_t MASK_EDGE_4PIN = 8'hFF;
  localparam byte_t MASK_EDGE_2PIN = 8'h0F;
  localparam byte_t MASK_PRI0 = 8'h7F;
  localparam byte_t MASK_PRI1 = 8'hFF;
  localparam byte_t MASK_PRI2 = 8'hFF;
  localparam byte_t MASK_PRI3_4PIN = 8'h33;
  localparam byte_t MASK_PRI3_2PIN = 8'h00;
  localparam byte_t MASK_GRP0 = 8'hFF;
  localparam byte_t MASK_GRP1 = 8'h77;
  localparam byte_t MASK_GRP2 = 8'hFF;
  localparam byte_t MASK_GRP3 = 8'h33;

  // Field positions
  localparam int BIT_GLOBAL_EN = 0;
  localparam int FLAG_LSB = 4;
  localparam int EDGE_FIELD_W = 2;

  localparam byte_t RESET_VAL = 8'h00;
  localparam int NUM_PRI_SRC = 15;
endpackage : irq_ctrl_pkg

// *** rtl/mcu_interrupt_flag_enable_logic.sv ***
`timescale 1ns/1ps
// Behaviour
// R1: Enabled request asks core to suspend; ack clears flag and global enable.
// R2: Sources: pins, timers, comparators, time base, LVD, EEPROM, serial, ADC.
// R3: Registers: primary controls, grouped controls, one external edge select.
// R4: Hardware sets a flag on its trigger; software writes enable bits.
// R5: Every source has its own enable bit and its own request flag.
// R6: Pin 1 edge field: 00 off, 01 rising, 10 falling, 11 both.
// R7: Pin 0 edge field sits in bits 1..0 with the same encoding.
// R8: With two pins, edge register bits 7..4 read as zero.
// R9: With four pins, pins 3 and 2 use bits 7..6 and 5..4.
// R10: Request needs flag, enable and global enable; groups fold sub-flags.
module mcu_interrupt_flag_enable_logic
  import irq_ctrl_pkg::*;
#(
  parameter int NUM_PINS = 2
) (
  input wire logic clk, // 10 MHz clock
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic [NUM_PINS-1:0] ext_pin, // External interrupt pins, async
  input wire logic [1:0] cmp_evt, // Comparator event pulses
  input wire logic adc_evt, // Converter done pulse
  input wire logic [1:0] tb_evt, // Time base pulses
  input wire logic [3:0] tmr_period_evt, // Timer period match pulses
  input wire logic [3:0] tmr_match_a_evt, // Timer compare A pulses
  input wire logic tmr_match_b_evt, // Timer 1 compare B pulse
  input wire logic sim_evt, // Serial interface pulse
  input wire logic lvd_evt, // Low voltage pulse
  input wire logic eeprom_evt, // EEPROM write done pulse
  input wire logic pinchange_evt, // Pin change pulse
  input wire irq_ctrl_pkg::reg_addr_t mem_addr, // Register index
  input wire logic mem_wr, // Write strobe
  input wire logic mem_rd, // Read strobe
  input wire irq_ctrl_pkg::byte_t mem_wdata, // Write data
  output irq_ctrl_pkg::byte_t mem_rdata, // Read data, one cycle later
  input wire logic irq_ack, // Core accepts the current request
  output logic irq_req, // Suspend request to core
  output irq_ctrl_pkg::src_idx_t irq_src // Pending primary source index
);
  import irq_ctrl_pkg::*;

  byte_t regs_r [0:NUM_REGS-1];
  byte_t regs_nxt [0:NUM_REGS-1];
  byte_t ev [0:NUM_REGS-1];
  byte_t clr [0:NUM_REGS-1];
  byte_t mask [0:NUM_REGS-1];
  logic [NUM_REGS-1:0] wr_sel;

  logic [NUM_PINS-1:0] sync1_r;
  logic [NUM_PINS-1:0] sync2_r;
  logic [NUM_PINS-1:0] prev_r;
  logic [3:0] pin_evt;
  logic [3:0] grp_evt;
  logic [NUM_PRI_SRC-1:0] pend;
  logic [NUM_PRI_SRC-1:0] clr_oh;
  logic ack_ok;
  logic global_irq_enable;
  logic irq_req_r;
  logic irq_req_nxt;
  src_idx_t irq_src_r;
  src_idx_t irq_src_nxt;
  byte_t rdata_r;
  byte_t rdata_nxt;
  logic addr_ok;

  function automatic src_idx_t first_set(input logic [NUM_PRI_SRC-1:0] v);
    src_idx_t idx;
    idx = 4'h0;
    for (int i = NUM_PRI_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = src_idx_t'(i);
      end
    end
    return idx;
  endfunction : first_set

  // Pin synchroniser and edge history
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
    end else if (ce) begin
      sync1_r <= ext_pin;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // Edge select decode per pin: bit 0 rising, bit 1 falling
  genvar gp;
  generate
    for (gp = 0; gp < 4; gp++) begin : g_pin
      if (gp < NUM_PINS) begin : g_on
        logic [EDGE_FIELD_W-1:0] sel;
        logic rise;
        logic fall;
        assign sel = regs_r[ADDR_EDGE][EDGE_FIELD_W*gp +: EDGE_FIELD_W];
        assign rise = sync2_r[gp] & ~prev_r[gp];
        assign fall = ~sync2_r[gp] & prev_r[gp];
        assign pin_evt[gp] = (sel[0] & rise) | (sel[1] & fall); // [R6] [R7] [R9]
      end else begin : g_off
        assign pin_evt[gp] = 1'b0;
      end
    end
  endgenerate

  // Grouped sources fold into their group flag while any is pending
  genvar gg;
  generate
    for (gg = 0; gg < 4; gg++) begin : g_grp
      assign grp_evt[gg] = |(regs_r[ADDR_GRP0 + gg][7:4]
                             & regs_r[ADDR_GRP0 + gg][3:0]); // [R10]
    end
  endgenerate

  // Hardware events placed on their flag positions
  assign ev[ADDR_EDGE] = RESET_VAL;
  assign ev[ADDR_PRI0] = {1'b0, cmp_evt[0], pin_evt[1], pin_evt[0], 4'h0}; // [R2] [R4]
  assign ev[ADDR_PRI1] = {adc_evt, grp_evt[1], grp_evt[0], cmp_evt[1],
                          4'h0}; // [R2] [R4]
  assign ev[ADDR_PRI2] = {grp_evt[3], tb_evt[1], tb_evt[0], grp_evt[2],
                          4'h0}; // [R2] [R4]
  assign ev[ADDR_PRI3] = {2'b00, pin_evt[3], pin_evt[2], 4'h0}; // [R9]
  assign ev[ADDR_GRP0] = {tmr_match_a_evt[2], tmr_period_evt[2],
                          tmr_match_a_evt[0], tmr_period_evt[0], 4'h0}; // [R2]
  assign ev[ADDR_GRP1] = {1'b0, tmr_match_b_evt, tmr_match_a_evt[1],
                          tmr_period_evt[1], 4'h0}; // [R2]
  assign ev[ADDR_GRP2] = {eeprom_evt, lvd_evt, pinchange_evt, sim_evt,
                          4'h0}; // [R2]
  assign ev[ADDR_GRP3] = {2'b00, tmr_match_a_evt[3], tmr_period_evt[3],
                          4'h0}; // [R2]

  // Implemented bits; the rest store nothing and read as zero
  assign mask[ADDR_EDGE] = (NUM_PINS > 2) ? MASK_EDGE_4PIN
                                          : MASK_EDGE_2PIN; // [R8]
  assign mask[ADDR_PRI0] = MASK_PRI0;
  assign mask[ADDR_PRI1] = MASK_PRI1;
  assign mask[ADDR_PRI2] = MASK_PRI2;
  assign mask[ADDR_PRI3] = (NUM_PINS > 2) ? MASK_PRI3_4PIN : MASK_PRI3_2PIN;
  assign mask[ADDR_GRP0] = MASK_GRP0;
  assign mask[ADDR_GRP1] = MASK_GRP1;
  assign mask[ADDR_GRP2] = MASK_GRP2;
  assign mask[ADDR_GRP3] = MASK_GRP3;

  // Primary pending vector: flag and its own enable
  assign pend = {regs_r[ADDR_PRI3][7:4] & regs_r[ADDR_PRI3][3:0],
                 regs_r[ADDR_PRI2][7:4] & regs_r[ADDR_PRI2][3:0],
                 regs_r[ADDR_PRI1][7:4] & regs_r[ADDR_PRI1][3:0],
                 regs_r[ADDR_PRI0][6:4] & regs_r[ADDR_PRI0][3:1]}; // [R5]
  assign global_irq_enable = regs_r[ADDR_PRI0][BIT_GLOBAL_EN];

  // Acceptance clears the serviced flag and the global enable
  assign ack_ok = ce & irq_ack & irq_req_r; // [R1]
  assign clr_oh = ack_ok ? (15'h0001 << irq_src_r) : '0;
  assign clr[ADDR_EDGE] = RESET_VAL;
  assign clr[ADDR_PRI0] = {1'b0, clr_oh[2:0], 3'b000, ack_ok}; // [R1]
  assign clr[ADDR_PRI1] = {clr_oh[6:3], 4'h0};
  assign clr[ADDR_PRI2] = {clr_oh[10:7], 4'h0};
  assign clr[ADDR_PRI3] = {clr_oh[14:11], 4'h0};
  assign clr[ADDR_GRP0] = RESET_VAL;
  assign clr[ADDR_GRP1] = RESET_VAL;
  assign clr[ADDR_GRP2] = RESET_VAL;
  assign clr[ADDR_GRP3] = RESET_VAL;

  // Register update: events win over software or ack clears
  genvar gr;
  generate
    for (gr = 0; gr < NUM_REGS; gr++) begin : g_reg
      assign wr_sel[gr] = mem_wr & (mem_addr == reg_addr_t'(gr)); // [R3]
      assign regs_nxt[gr] = (((wr_sel[gr] ? mem_wdata : regs_r[gr])
                             & ~clr[gr]) | ev[gr]) & mask[gr]; // [R4] [R5]
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          regs_r[gr] <= RESET_VAL;
        end else if (ce) begin
          regs_r[gr] <= regs_nxt[gr];
        end
      end
    end
  endgenerate

  // Core request and read-back
  assign irq_req_nxt = global_irq_enable & (|pend) & ~ack_ok; // [R10] [R1]
  assign irq_src_nxt = first_set(pend);
  assign addr_ok = mem_addr < reg_addr_t'(NUM_REGS);
  assign rdata_nxt = (mem_rd && addr_ok) ? regs_r[mem_addr] : RESET_VAL; // [R8]

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_req_r <= 1'b0;
      irq_src_r <= 4'h0;
      rdata_r <= RESET_VAL;
    end else if (ce) begin
      irq_req_r <= irq_req_nxt;
      irq_src_r <= irq_src_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign irq_req = irq_req_r;
  assign irq_src = irq_src_r;
  assign mem_rdata = rdata_r;

  a_accept_clears_global: assert property ( // [R1]
    @(posedge clk) disable iff (!resetn)
    ack_ok && !wr_sel[ADDR_PRI0] |=> !regs_r[ADDR_PRI0][BIT_GLOBAL_EN] &&
      !irq_req_r)
    else $error("accepted request did not clear global enable");

  a_adc_flag_set: assert property ( // [R2]
    @(posedge clk) disable iff (!resetn)
    ce && adc_evt |=> regs_r[ADDR_PRI1][7])
    else $error("converter event did not set its flag");

  a_cmp_flag_set: assert property ( // [R4]
    @(posedge clk) disable iff (!resetn)
    ce && cmp_evt[0] |=> regs_r[ADDR_PRI0][6])
    else $error("comparator event lost");

  a_enable_blocks: assert property ( // [R5]
    @(posedge clk) disable iff (!resetn)
    ce && pend == '0 |=> !irq_req_r)
    else $error("request raised with nothing enabled and pending");

  a_edge_pin1_fall: assert property ( // [R6]
    @(posedge clk) disable iff (!resetn)
    ce && regs_r[ADDR_EDGE][3:2] == 2'b10 && !sync2_r[1] && prev_r[1]
    |=> regs_r[ADDR_PRI0][5])
    else $error("pin 1 falling edge not flagged");

  a_edge_pin0_off: assert property ( // [R7]
    @(posedge clk) disable iff (!resetn)
    regs_r[ADDR_EDGE][1:0] == 2'b00 |-> !pin_evt[0])
    else $error("pin 0 triggered while disabled");

  a_edge_pin0_rise: assert property ( // [R7]
    @(posedge clk) disable iff (!resetn)
    ce && regs_r[ADDR_EDGE][1:0] == 2'b01 && sync2_r[0] && !prev_r[0]
    |=> regs_r[ADDR_PRI0][4])
    else $error("pin 0 rising edge not flagged");

  a_upper_zero: assert property ( // [R8]
    @(posedge clk) disable iff (!resetn)
    NUM_PINS == 2 |-> regs_r[ADDR_EDGE][7:4] == 4'h0 &&
      regs_r[ADDR_PRI3] == 8'h00)
    else $error("unimplemented edge bits not zero");

  a_group_fold: assert property ( // [R10]
    @(posedge clk) disable iff (!resetn)
    ce && grp_evt[0] |=> regs_r[ADDR_PRI1][5])
    else $error("group flag not set from sub-source");

  a_req_needs_global: assert property ( // [R10]
    @(posedge clk) disable iff (!resetn)
    ce && !global_irq_enable |=> !irq_req_r)
    else $error("request raised with global enable clear");

  a_ce_freezes: assert property ( // [R4]
    @(posedge clk) disable iff (!resetn)
    !ce |=> $stable(regs_r[ADDR_PRI1]) && $stable(irq_req_r))
    else $error("state changed while clock enable was low");

  a_edge_pin1_rise: assert property ( // [R6]
    @(posedge clk) disable iff (!resetn)
    ce && regs_r[ADDR_EDGE][3:2] == 2'b01 && sync2_r[1] && !prev_r[1]
    |=> regs_r[ADDR_PRI0][5])
    else $error("pin 1 rising edge not flagged");

  a_edge_pin1_both: assert property ( // [R6]
    @(posedge clk) disable iff (!resetn)
    ce && regs_r[ADDR_EDGE][3:2] == 2'b11 && (sync2_r[1] != prev_r[1])
    |=> regs_r[ADDR_PRI0][5])
    else $error("pin 1 edge missed with both edges selected");

  a_edge_pin0_fall: assert property ( // [R7]
    @(posedge clk) disable iff (!resetn)
    ce && regs_r[ADDR_EDGE][1:0] == 2'b10 && !sync2_r[0] && prev_r[0]
    |=> regs_r[ADDR_PRI0][4])
    else $error("pin 0 falling edge not flagged");

  a_ack_clears_flag: assert property ( // [R1]
    @(posedge clk) disable iff (!resetn)
    ack_ok && irq_src_r == 4'h2 && !cmp_evt[0] |=> !regs_r[ADDR_PRI0][6])
    else $error("accepted comparator request left its flag set");

  a_src_lowest: assert property ( // [R10]
    @(posedge clk) disable iff (!resetn)
    ce && pend[0] |=> irq_src_r == 4'h0)
    else $error("lowest pending source not reported");

  a_req_raise: assert property ( // [R10]
    @(posedge clk) disable iff (!resetn)
    ce && global_irq_enable && (|pend) && !ack_ok |=> irq_req_r)
    else $error("enabled pending request not raised");

  a_refused_read: assert property ( // [R3]
    @(posedge clk) disable iff (!resetn)
    ce && mem_rd && !addr_ok |=> rdata_r == RESET_VAL)
    else $error("read of an unused index returned data");

  a_pin3_flag: assert property ( // [R9]
    @(posedge clk) disable iff (!resetn)
    ce && pin_evt[3] |=> regs_r[ADDR_PRI3][5])
    else $error("pin 3 edge not flagged");
endmodule : mcu_interrupt_flag_enable_logic

// *** sim/irq_core_model.sv ***
`timescale 1ns/1ps
module irq_core_model (
  input wire logic clk, // System clock
  input wire logic resetn, // Reset, active low
  input wire logic irq_req, // Request from the controller
  input wire logic ack_on, // Core may take requests
  input wire logic [1:0] lat, // Request cycles before acceptance
  input wire irq_ctrl_pkg::src_idx_t irq_src, // Pending source
  output logic irq_ack, // Acceptance pulse
  output irq_ctrl_pkg::src_idx_t src_seen // Source taken at acceptance
);
  import irq_ctrl_pkg::*;
  logic [1:0] wait_r;
  // One pulse per standing request, after a chosen delay
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_r <= 2'h0;
      irq_ack <= 1'b0;
      src_seen <= 4'h0;
    end else begin
      irq_ack <= ack_on && irq_req && !irq_ack && (wait_r >= lat);
      if (irq_req && !irq_ack && wait_r != 2'h3) begin
        wait_r <= wait_r + 2'h1;
      end else if (!irq_req) begin
        wait_r <= 2'h0;
      end
      if (irq_ack && irq_req) begin
        src_seen <= irq_src;
      end
    end
  end
endmodule : irq_core_model

// *** sim/mcu_interrupt_flag_enable_logic_tb_top.sv ***
`timescale 1ns/1ps
module mcu_interrupt_flag_enable_logic_tb_top;
  import irq_ctrl_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] pins = 2'h0;
  logic [3:0] pins4 = 4'h0;
  logic ce = 1'b1;
  byte_t rdata4;
  logic [17:0] ev = 18'h0_0000;
  reg_addr_t mem_addr = 4'h0;
  logic mem_wr = 1'b0;
  logic mem_rd = 1'b0;
  byte_t mem_wdata = 8'h00;
  byte_t mem_rdata;
  logic irq_ack, irq_req, ack_on = 1'b0;
  logic [1:0] lat = 2'h0;
  src_idx_t irq_src, src_seen;
  int error_cnt = 0;
  int cmp_count = 0;
  always #50 clk = ~clk;
  mcu_interrupt_flag_enable_logic #(.NUM_PINS(2)) dut_u (.clk(clk),
    .resetn(resetn), .ce(ce), .ext_pin(pins), .cmp_evt(ev[1:0]),
    .adc_evt(ev[2]), .tb_evt(ev[4:3]), .tmr_period_evt(ev[8:5]),
    .tmr_match_a_evt(ev[12:9]), .tmr_match_b_evt(ev[13]),
    .sim_evt(ev[14]), .lvd_evt(ev[15]), .eeprom_evt(ev[16]),
    .pinchange_evt(ev[17]), .mem_addr(mem_addr), .mem_wr(mem_wr),
    .mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .irq_ack(irq_ack), .irq_req(irq_req), .irq_src(irq_src));
  mcu_interrupt_flag_enable_logic #(.NUM_PINS(4)) dut4_u (.clk(clk),
    .resetn(resetn), .ce(ce), .ext_pin(pins4), .cmp_evt(ev[1:0]),
    .adc_evt(ev[2]), .tb_evt(ev[4:3]), .tmr_period_evt(ev[8:5]),
    .tmr_match_a_evt(ev[12:9]), .tmr_match_b_evt(ev[13]),
    .sim_evt(ev[14]), .lvd_evt(ev[15]), .eeprom_evt(ev[16]),
    .pinchange_evt(ev[17]), .mem_addr(mem_addr), .mem_wr(mem_wr),
    .mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_rdata(rdata4),
    .irq_ack(irq_ack), .irq_req(), .irq_src());
  irq_core_model core_u (.clk(clk), .resetn(resetn), .irq_req(irq_req),
    .ack_on(ack_on), .lat(lat), .irq_src(irq_src), .irq_ack(irq_ack),
    .src_seen(src_seen));
  function automatic byte_t mask(int a);
    byte_t m [10] = '{MASK_EDGE_2PIN, MASK_PRI0, MASK_PRI1, MASK_PRI2,
      MASK_PRI3_2PIN, MASK_GRP0, MASK_GRP1, MASK_GRP2, MASK_GRP3, 8'h00};
    return m[a];
  endfunction : mask
  task automatic step;
    @(posedge clk);
    #10;
  endtask : step
  task automatic chk(string n, byte_t e, byte_t s);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(int a, byte_t d);
    step;
    mem_addr = a[3:0];
    mem_wdata = d;
    mem_wr = 1'b1;
    step;
    mem_wr = 1'b0;
  endtask : wr
  task automatic rchk(int a, byte_t e);
    step;
    mem_addr = a[3:0];
    mem_rd = 1'b1;
    step;
    mem_rd = 1'b0;
    chk($sformatf("reg %0d", a), e, mem_rdata);
  endtask : rchk
  task automatic pulse(int k);
    step;
    ev[k] = 1'b1;
    step;
    ev[k] = 1'b0;
  endtask : pulse
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  initial begin
    #2000000;
    error_cnt++;
    results;
  end
  initial begin
    int pa [5] = '{1, 2, 2, 3, 3};
    int pf [5] = '{6, 4, 7, 5, 6};
    int pe [5] = '{3, 0, 3, 1, 2};
    int ps [5] = '{2, 3, 6, 8, 9};
    int ga [13] = '{5, 6, 5, 8, 5, 6, 5, 8, 6, 7, 7, 7, 7};
    int gb [13] = '{4, 4, 6, 4, 5, 5, 7, 5, 6, 4, 6, 7, 5};
    int gp [4] = '{2, 2, 3, 3};
    int gf [4] = '{5, 6, 4, 7};
    int n, g;
    byte_t d;
    void'($urandom(46776));
    repeat (12) @(posedge clk);
    #10;
    resetn = 1'b1;
    for (int a = 0; a < 16; a++) rchk(a, 8'h00);
    for (int a = 0; a < 10; a++) begin
      d = byte_t'($urandom);
      wr(a, d);
      rchk(a, d & mask(a));
    end
    for (int a = 9; a >= 0; a--) wr(a, 8'h00);
    for (int k = 0; k < 5; k++) begin
      lat = 2'($urandom);
      wr(pa[k], 8'h01 << pe[k]);
      pulse(k);
      rchk(pa[k], (8'h01 << pe[k]) | (8'h01 << pf[k]));
      chk("req without global", 8'h00, {7'h00, irq_req});
      if (pa[k] == 1) wr(1, 8'h01 | (8'h01 << pe[k]) | (8'h01 << pf[k]));
      else wr(1, 8'h01);
      step;
      chk("req", 8'h01, {7'h00, irq_req});
      chk("src", byte_t'(ps[k]), {4'h0, irq_src});
      ack_on = 1'b1;
      n = 0;
      while (irq_req !== 1'b0 && n < 20) begin
        step;
        n++;
      end
      ack_on = 1'b0;
      chk("taken src", byte_t'(ps[k]), {4'h0, src_seen});
      rchk(pa[k], 8'h01 << pe[k]);
      if (pa[k] != 1) rchk(1, 8'h00);
      wr(pa[k], 8'h00);
    end
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 4; m++) begin
        wr(0, byte_t'(m << (2 * p)));
        step;
        pins[p] = 1'b1;
        repeat (4) step;
        rchk(1, byte_t'((m & 1) << (4 + p)));
        wr(1, 8'h00);
        pins[p] = 1'b0;
        repeat (4) step;
        rchk(1, byte_t'((m >> 1) << (4 + p)));
        wr(1, 8'h00);
      end
    end
    for (int p = 2; p < 4; p++) begin
      wr(0, byte_t'(8'h03 << (2 * p)));
      rchk(0, 8'h00);
      chk("edge reg 4pin", byte_t'(8'h03 << (2 * p)), rdata4);
      pins4[p] = 1'b1;
      repeat (4) step;
      pins4[p] = 1'b0;
      repeat (4) step;
      rchk(4, 8'h00);
      chk("pin flag 4pin", byte_t'(8'h10 << (p - 2)), rdata4);
      wr(4, 8'h00);
    end
    wr(0, 8'h00);
    for (int k = 0; k < 13; k++) begin
      g = ga[k] - 5;
      wr(ga[k], 8'h0f);
      pulse(k + 5);
      rchk(ga[k], ((8'h01 << gb[k]) | 8'h0f) & mask(ga[k]));
      rchk(gp[g], 8'h01 << gf[g]);
      wr(ga[k], 8'h00);
      wr(gp[g], 8'h00);
    end
    ce = 1'b0;
    wr(1, 8'h7f);
    pulse(2);
    step;
    ce = 1'b1;
    rchk(1, 8'h00);
    rchk(2, 8'h00);
    results;
  end
endmodule : mcu_interrupt_flag_enable_logic_tb_top
